//--- logic/wfb_pkg.sv
// What this block does
// [R1] Buffer config bit 5 picks the fill data: 0 takes resampled samples, 1 takes fixed-rate samples.
// [R2] A capture starts only when the capture enable bit 4 goes from 0 to 1, using the chosen data type and source.
// [R3] While capture enable is 0 nothing is captured and the buffer keeps its contents and stays readable.
// [R4] The 4-bit burst channel select picks the burst data: 0000 all channels, 0001 phase A, then phase B and C pairs.
// [R5] Burst channel select 1111 turns burst reading off and serves single-address reads only.
// [R6] Neutral current samples come back from a burst only when the neutral readout enable bit is 1.
// [R7] Writing 1 to trigger config bit 10 makes a forced trigger that stops buffer filling.
// [R8] Trigger config bits 9 to 6 enable the combined, phase C, phase B and phase A voltage zero crossings.
// [R9] Trigger config bits 5, 4 and 3 enable the phase C, B and A current zero crossings.
// [R10] Trigger config bit 2 enables over-current, bit 1 swell and bit 0 dip events of any phase.
// [R11] During fixed-rate filling, status bits 15 to 12 show the page of the buffer filled last.
// [R12] Read-only status bits 10 to 0 hold the buffer address of the last sample stored after a trigger.
// [R13] The 2-bit fill mode picks stop when full, stop on trigger, centre on trigger or save trigger address.
// [R14] The 2-bit source field picks filter output at 32 kSPS or filter plus low-pass output at 8 kSPS.
// [R15] The neutral readout enable bit lets neutral samples be read out over the serial port when it is 1.
// [R16] Events whose trigger enable bit is clear leave filling, trigger address and last page untouched.
// [R17] All configuration fields and both status fields reset to zero.
package wfb_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] WFB_ADDR_BUF_CFG = 12'h4A0;
  localparam logic [11:0] WFB_ADDR_TRG_CFG = 12'h4A2;
  localparam logic [11:0] WFB_ADDR_TRG_STAT = 12'h4A3;
  localparam logic [15:0] WFB_BUF_CFG_WMASK = 16'h13FF;
  localparam logic [15:0] WAVEFORM_TRIGGER_CONFIG_WMASK = 16'h07FF;
  localparam logic [15:0] WFB_REG_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int WFB_CAP_SEL_BIT = 5;
  localparam int WFB_CAP_EN_BIT = 4;
  localparam int WFB_BURST_MSB = 3;
  localparam int WFB_MODE_MSB = 7;
  localparam int WFB_MODE_LSB = 6;
  localparam int WFB_SRC_MSB = 9;
  localparam int WFB_SRC_LSB = 8;
  localparam int WFB_IN_EN_BIT = 12;
  localparam int WFB_FORCE_BIT = 10;
  localparam int WFB_TRIG_EN_MSB = 9;
  localparam int WFB_PAGE_MSB = 15;
  localparam int WFB_PAGE_LSB = 12;

  // ----------------------------------------------------------------
  // Buffer geometry
  // ----------------------------------------------------------------
  localparam int WFB_WORD_W = 32;
  localparam int WFB_CH_W = 3;
  localparam int WFB_SET_WORDS = 8;
  localparam int WFB_SETS = 256;
  localparam int WFB_IDX_W = 8;
  localparam int WFB_ADDR_W = 11;
  localparam int WFB_PAGE_W = 4;
  localparam int WFB_PAGE_SET_BITS = 4;
  localparam logic [WFB_IDX_W-1:0] WFB_HALF_SETS = 8'h80;
  localparam logic [WFB_CH_W-1:0] WFB_CH_FIRST = 3'h0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] WFB_SRC_32K = 2'h0;
  localparam logic [1:0] WFB_SRC_8K = 2'h2;
  localparam logic [3:0] WFB_BURST_ALL = 4'h0;
  localparam logic [3:0] WFB_BURST_A = 4'h1;
  localparam logic [3:0] WFB_BURST_B = 4'h2;
  localparam logic [3:0] WFB_BURST_C = 4'h3;
  localparam logic [3:0] WFB_BURST_N = 4'h4;
  localparam logic [3:0] WFB_BURST_SINGLE = 4'hF;
  localparam logic [7:0] WFB_MASK_ALL = 8'h3F;
  localparam logic [7:0] WFB_MASK_A = 8'h03;
  localparam logic [7:0] WFB_MASK_B = 8'h0C;
  localparam logic [7:0] WFB_MASK_C = 8'h30;
  localparam logic [7:0] WFB_MASK_N = 8'h40;
  localparam logic [7:0] WFB_MASK_NONE = 8'h00;

  typedef enum logic [1:0] {
    WFB_FILL_STOP_FULL,
    WFB_FILL_STOP_TRIG,
    WFB_FILL_CENTRE,
    WFB_FILL_SAVE_ADDR
  } wfb_fill_mode_type;

  typedef enum logic [1:0] {CAP_IDLE, CAP_FILL, CAP_POST} wfb_cap_state_type;
  typedef enum logic {RD_IDLE, RD_BURST} wfb_rd_state_type;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef logic [WFB_SET_WORDS-1:0][WFB_WORD_W-1:0] wfb_set_type;

  typedef struct packed {
    logic combined_voltage_crossing;
    logic phase_c_voltage_crossing;
    logic phase_b_voltage_crossing;
    logic phase_a_voltage_crossing;
    logic phase_c_current_crossing;
    logic phase_b_current_crossing;
    logic phase_a_current_crossing;
    logic overcurrent_trigger;
    logic swell;
    logic dip;
  } wfb_event_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } wfb_reg_req_type;

  typedef struct packed {
    logic [15:0] buf_cfg;
    logic [15:0] trg_cfg;
    logic [WFB_PAGE_W-1:0] last_filled_page;
    logic [WFB_ADDR_W-1:0] trigger_sample_address;
    logic cap_en_prev;
    wfb_cap_state_type cap_state;
    logic [WFB_IDX_W-1:0] widx;
    logic trig_pend;
    logic [WFB_IDX_W-1:0] post_cnt;
    wfb_rd_state_type rd_state;
    logic [WFB_IDX_W-1:0] rd_set;
    logic [WFB_CH_W-1:0] rd_ch;
    logic [7:0] rd_mask;
    logic [WFB_WORD_W-1:0] rd_data;
    logic rd_valid;
    logic rd_last;
    logic rd_busy;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic capture_active;
  } wfb_state_type;

endpackage

//--- logic/wfb_sample_store.sv
module wfb_sample_store
  import wfb_pkg::*;
#(
  parameter int DEPTH = WFB_SETS,
  parameter int IDX_W = WFB_IDX_W,
  parameter int ROW_W = WFB_SET_WORDS * WFB_WORD_W
) (
  // Clock.
  input wire logic clk_sys,
  // Write side.
  input wire logic we,
  input wire logic [IDX_W-1:0] widx,
  input wire logic [ROW_W-1:0] wdata,
  // Read side.
  input wire logic [IDX_W-1:0] ridx,
  output logic [ROW_W-1:0] rdata
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [DEPTH-1:0][ROW_W-1:0] mem_reg;
  logic [DEPTH-1:0][ROW_W-1:0] mem_next;

  always_comb begin
    mem_next = mem_reg;
    if (we) begin
      mem_next[widx] = wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    mem_reg <= mem_next;
  end

  assign rdata = mem_reg[ridx];

endmodule

//--- logic/wfb_capture_trigger.sv
module wfb_capture_trigger
  import wfb_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Register access.
  input wire wfb_reg_req_type reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Sample inputs.
  input wire logic strobe_32k,
  input wire logic strobe_8k,
  input wire wfb_set_type fixed_samples,
  input wire logic resampled_strobe,
  input wire wfb_set_type resampled_samples,
  // Trigger events.
  input wire wfb_event_type events,
  // Buffer read port.
  input wire logic rd_req,
  input wire logic [WFB_ADDR_W-1:0] rd_addr,
  output logic [WFB_WORD_W-1:0] rd_data,
  output logic rd_valid,
  output logic rd_last,
  output logic rd_busy,
  // Status.
  output logic capture_active
);

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic logic [7:0] chan_mask(input logic [3:0] sel, input logic in_en);
    logic [7:0] m;
    m = WFB_MASK_NONE;
    unique case (sel)
      WFB_BURST_ALL: m = in_en ? (WFB_MASK_ALL | WFB_MASK_N) : WFB_MASK_ALL;
      WFB_BURST_A: m = WFB_MASK_A;
      WFB_BURST_B: m = WFB_MASK_B;
      WFB_BURST_C: m = WFB_MASK_C;
      WFB_BURST_N: m = in_en ? WFB_MASK_N : WFB_MASK_NONE;
      default: m = WFB_MASK_NONE;
    endcase
    return m;
  endfunction

  function automatic logic more_after(input logic [7:0] m, input logic [WFB_CH_W-1:0] c);
    return (m >> c) > 8'h01;
  endfunction

  function automatic logic hits(input logic [11:0] a, input logic [11:0] b);
    return a == b;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wfb_state_type s_reg;
  wfb_state_type s_next;
  wfb_set_type row;
  logic buf_we;
  logic [WFB_IDX_W-1:0] rd_idx;
  wfb_set_type buf_wdata;

  wfb_sample_store #(
    .DEPTH(WFB_SETS),
    .IDX_W(WFB_IDX_W),
    .ROW_W(WFB_SET_WORDS * WFB_WORD_W)
  ) wfb_sample_store_i (
    .clk_sys(clk_sys),
    .we(buf_we),
    .widx(s_reg.widx),
    .wdata(buf_wdata),
    .ridx(rd_idx),
    .rdata(row)
  );

  always_comb begin
    logic force_pulse;
    logic cap_en;
    logic fixed;
    logic strobe;
    logic hit;
    logic [1:0] src;
    logic [7:0] mask;
    wfb_fill_mode_type mode;
    force_pulse = 1'b0;
    cap_en = 1'b0;
    fixed = 1'b0;
    strobe = 1'b0;
    hit = 1'b0;
    src = WFB_SRC_32K;
    mask = WFB_MASK_NONE;
    mode = WFB_FILL_STOP_FULL;
    s_next = s_reg;
    s_next.reg_rvalid = 1'b0;
    s_next.rd_valid = 1'b0;
    s_next.rd_last = 1'b0;
    buf_we = 1'b0;

    // ----------------------------------------------------------------
    // Register writes and reads
    // ----------------------------------------------------------------
    if (reg_req.wr) begin
      if (hits(reg_req.addr, WFB_ADDR_BUF_CFG)) begin
        s_next.buf_cfg = reg_req.wdata & WFB_BUF_CFG_WMASK;
      end
      if (hits(reg_req.addr, WFB_ADDR_TRG_CFG)) begin
        s_next.trg_cfg = reg_req.wdata & WAVEFORM_TRIGGER_CONFIG_WMASK;
        force_pulse = reg_req.wdata[WFB_FORCE_BIT]; // [R7]
      end
      if (hits(reg_req.addr, WFB_ADDR_TRG_STAT)) begin
        s_next.last_filled_page = reg_req.wdata[WFB_PAGE_MSB:WFB_PAGE_LSB];
      end
    end
    if (reg_req.rd) begin
      s_next.reg_rvalid = 1'b1;
      s_next.reg_rdata = WFB_REG_RESET;
      if (hits(reg_req.addr, WFB_ADDR_BUF_CFG)) begin
        s_next.reg_rdata = s_reg.buf_cfg;
      end
      if (hits(reg_req.addr, WFB_ADDR_TRG_CFG)) begin
        s_next.reg_rdata = s_reg.trg_cfg;
      end
      if (hits(reg_req.addr, WFB_ADDR_TRG_STAT)) begin
        s_next.reg_rdata[WFB_PAGE_MSB:WFB_PAGE_LSB] = s_reg.last_filled_page;
        s_next.reg_rdata[WFB_ADDR_W-1:0] = s_reg.trigger_sample_address;
      end
    end

    // ----------------------------------------------------------------
    // Capture control
    // ----------------------------------------------------------------
    cap_en = s_reg.buf_cfg[WFB_CAP_EN_BIT];
    fixed = s_reg.buf_cfg[WFB_CAP_SEL_BIT];
    src = s_reg.buf_cfg[WFB_SRC_MSB:WFB_SRC_LSB];
    mode = wfb_fill_mode_type'(s_reg.buf_cfg[WFB_MODE_MSB:WFB_MODE_LSB]);
    if (fixed) begin
      strobe = (src == WFB_SRC_32K) ? strobe_32k : ((src == WFB_SRC_8K) ? strobe_8k : 1'b0); // [R14]
    end else begin
      strobe = resampled_strobe;
    end
    buf_wdata = fixed ? fixed_samples : resampled_samples; // [R1]
    hit = (|(events & s_reg.trg_cfg[WFB_TRIG_EN_MSB:0])) | force_pulse; // [R8] [R9] [R10] [R16]
    s_next.cap_en_prev = cap_en;

    if (!cap_en) begin
      s_next.cap_state = CAP_IDLE; // [R3]
      s_next.trig_pend = 1'b0;
    end else if (!s_reg.cap_en_prev) begin
      s_next.cap_state = CAP_FILL; // [R2]
      s_next.widx = '0;
      s_next.trig_pend = 1'b0;
    end else if (s_reg.cap_state != CAP_IDLE) begin
      if (hit && s_reg.cap_state == CAP_FILL) begin
        s_next.trig_pend = 1'b1;
      end
      if (strobe) begin
        buf_we = 1'b1;
        s_next.widx = WFB_IDX_W'(s_reg.widx + 1'b1);
        if (fixed && (&s_reg.widx[WFB_PAGE_SET_BITS-1:0])) begin
          s_next.last_filled_page = s_reg.widx[WFB_IDX_W-1:WFB_PAGE_SET_BITS]; // [R11]
        end
        if (s_reg.cap_state == CAP_POST) begin
          s_next.post_cnt = WFB_IDX_W'(s_reg.post_cnt - 1'b1);
          if (s_reg.post_cnt == WFB_IDX_W'(1)) begin
            s_next.cap_state = CAP_IDLE;
          end
        end else if (s_reg.trig_pend || hit) begin
          s_next.trig_pend = 1'b0;
          s_next.trigger_sample_address = {s_reg.widx, WFB_CH_FIRST}; // [R12]
          unique case (mode) // [R13]
            WFB_FILL_STOP_FULL: s_next.cap_state = CAP_IDLE;
            WFB_FILL_STOP_TRIG: s_next.cap_state = CAP_IDLE; // [R7]
            WFB_FILL_CENTRE: begin
              s_next.cap_state = CAP_POST;
              s_next.post_cnt = WFB_HALF_SETS;
            end
            WFB_FILL_SAVE_ADDR: s_next.cap_state = CAP_FILL;
          endcase
        end else if ((&s_reg.widx) && (!fixed || mode == WFB_FILL_STOP_FULL)) begin
          s_next.cap_state = CAP_IDLE; // [R13]
        end
      end
    end
    s_next.capture_active = s_next.cap_state != CAP_IDLE;

    // ----------------------------------------------------------------
    // Buffer read engine
    // ----------------------------------------------------------------
    rd_idx = (s_reg.rd_state == RD_BURST) ? s_reg.rd_set : rd_addr[WFB_ADDR_W-1:WFB_CH_W];
    unique case (s_reg.rd_state)
      RD_IDLE: begin
        if (rd_req) begin
          mask = chan_mask(s_reg.buf_cfg[WFB_BURST_MSB:0], s_reg.buf_cfg[WFB_IN_EN_BIT]); // [R4] [R6] [R15]
          if (s_reg.buf_cfg[WFB_BURST_MSB:0] == WFB_BURST_SINGLE || mask == WFB_MASK_NONE) begin
            s_next.rd_data = row[rd_addr[WFB_CH_W-1:0]]; // [R5]
            s_next.rd_valid = 1'b1;
            s_next.rd_last = 1'b1;
          end else begin
            s_next.rd_state = RD_BURST;
            s_next.rd_set = rd_addr[WFB_ADDR_W-1:WFB_CH_W];
            s_next.rd_ch = WFB_CH_FIRST;
            s_next.rd_mask = mask;
            s_next.rd_busy = 1'b1;
          end
        end
      end
      RD_BURST: begin
        if (s_reg.rd_mask[s_reg.rd_ch]) begin
          s_next.rd_data = row[s_reg.rd_ch]; // [R4]
          s_next.rd_valid = 1'b1;
          s_next.rd_last = !more_after(s_reg.rd_mask, s_reg.rd_ch);
        end
        s_next.rd_ch = WFB_CH_W'(s_reg.rd_ch + 1'b1);
        if (!more_after(s_reg.rd_mask, s_reg.rd_ch)) begin
          s_next.rd_state = RD_IDLE;
          s_next.rd_busy = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0; // [R17]
      s_reg.cap_state <= CAP_IDLE;
      s_reg.rd_state <= RD_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s_reg.reg_rdata;
  assign reg_rvalid = s_reg.reg_rvalid;
  assign rd_data = s_reg.rd_data;
  assign rd_valid = s_reg.rd_valid;
  assign rd_last = s_reg.rd_last;
  assign rd_busy = s_reg.rd_busy;
  assign capture_active = s_reg.capture_active;

endmodule

//--- tb/wfb_sample_src.sv
module wfb_sample_src
  import wfb_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Fixed-rate samples.
  output logic strobe_32k,
  output logic strobe_8k,
  output wfb_set_type samples,
  output logic [15:0] seq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Sample source
  // ----
  logic [4:0] cnt;
  // A ready pulse every twenty cycles.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= 5'h00;
      seq <= 16'h0000;
      strobe_32k <= 1'b0;
      strobe_8k <= 1'b0;
    end else begin
      strobe_32k <= cnt == 5'h13;
      strobe_8k <= (cnt == 5'h13) && (seq[1:0] == 2'h3);
      cnt <= (cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
      if (strobe_32k) seq <= seq + 16'h0001;
    end
  end
  // Each word carries the set number and its channel.
  always_comb begin
    for (int c = 0; c < 8; c++) samples[c] = {seq, 13'h0000, 3'(c)};
  end
endmodule

//--- tb/wfb_capture_trigger_properties.sv
module wfb_trig_checker
  import wfb_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Register access.
  input wire wfb_reg_req_type reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  // Buffer read and status.
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic rd_last,
  input wire logic rd_busy,
  input wire logic capture_active
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Properties
  // ----
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic en_reg;
  wire cfg_wr = reg_req.wr && reg_req.addr == WFB_ADDR_BUF_CFG;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) en_reg <= 1'b0;
    else if (cfg_wr) en_reg <= reg_req.wdata[4];
  end
  a_read_answer: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_req.rd))
    else $error("stray read answer");
  a_trg_reserved: assert property (reg_req.rd && reg_req.addr == WFB_ADDR_TRG_CFG |=> reg_rdata[15:11] == 5'h00)
    else $error("trigger config reserved bits set");
  a_stat_reserved: assert property (reg_req.rd && reg_req.addr == WFB_ADDR_TRG_STAT |=> !reg_rdata[11])
    else $error("status reserved bit set");
  a_cap_start: assert property (cfg_wr && reg_req.wdata[4] && !en_reg |-> ##2 capture_active)
    else $error("capture did not start");
  a_start_cause: assert property ($rose(capture_active) |-> $past(cfg_wr && reg_req.wdata[4] && !en_reg, 2))
    else $error("capture started without enable edge");
  a_stop_clear: assert property (cfg_wr && !reg_req.wdata[4] |-> ##[1:2] !capture_active)
    else $error("capture kept running");
  a_last_valid: assert property (rd_last |-> rd_valid)
    else $error("last without valid");
  a_burst_bound: assert property ($rose(rd_busy) |-> ##[1:9] !rd_busy)
    else $error("burst too long");
  a_no_stray: assert property (rd_valid |-> $past(rd_req) || $past(rd_busy))
    else $error("read data without request");
endmodule

//--- tb/wfb_capture_trigger_tb_top.sv
module wfb_capture_trigger_tb_top;
  import wfb_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Bench
  // ----
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  wfb_reg_req_type reg_req = '0;
  wfb_event_type events = '0;
  logic rd_req = 1'b0;
  logic [10:0] rd_addr = 11'h000;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic [31:0] rd_data;
  logic rd_valid;
  logic rd_last;
  logic rd_busy;
  logic capture_active;
  logic strobe_32k;
  logic strobe_8k;
  logic use_8k = 1'b0;
  logic inv = 1'b0;
  wfb_set_type fixed_samples;
  wfb_set_type resampled_samples;
  logic [15:0] seq;
  logic [15:0] seqs [256];
  int errors = 0;
  int n_checks = 0;
  int n = 0;
  int codes [6] = '{0, 1, 2, 3, 4, 15};

  wfb_sample_src wfb_sample_src_i (.clk_sys(clk_sys), .rst(rst), .strobe_32k(strobe_32k), .strobe_8k(strobe_8k),
    .samples(fixed_samples), .seq(seq));
  // The resampled path carries the inverted fixed-rate words so that the two can be told apart.
  assign resampled_samples = ~fixed_samples;
  wfb_capture_trigger wfb_capture_trigger_i (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .strobe_32k(strobe_32k), .strobe_8k(strobe_8k),
    .fixed_samples(fixed_samples), .resampled_strobe(strobe_32k), .resampled_samples(resampled_samples),
    .events(events),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .rd_last(rd_last),
    .rd_busy(rd_busy), .capture_active(capture_active));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // Records the set number of every stored sample set.
  always @(posedge clk_sys) begin
    if (capture_active && (use_8k ? strobe_8k : strobe_32k)) begin
      seqs[n] = seq;
      n = n + 1;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_sys) reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys) reg_req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk_sys) reg_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_sys) reg_req <= '0;
    #1 chk("reg_rdata", {15'h0000, 1'b1, exp}, {15'h0000, reg_rvalid, reg_rdata});
  endtask
  task automatic wait_n(input int t);
    for (int k = 0; k < 2000 && n < t; k++) @(posedge clk_sys);
  endtask
  // Runs one capture stopped by source i, where 10 is the forced trigger.
  task automatic capture(input int i);
    wr(WFB_ADDR_BUF_CFG, 16'h0000);
    wr(WFB_ADDR_TRG_CFG, i < 10 ? 16'(1 << i) : 16'h0000);
    n = 0;
    wr(WFB_ADDR_BUF_CFG, 16'h0070);
    wait_n(i == 0 ? 34 : 2);
    @(posedge clk_sys) events <= wfb_event_type'(10'(1) << ((i + 1) % 10));
    @(posedge clk_sys) events <= '0;
    wait_n(n + 1);
    chk("capture_active", 32'h1, {31'h0, capture_active});
    if (i < 10) begin
      @(posedge clk_sys) events <= wfb_event_type'(10'(1) << i);
      @(posedge clk_sys) events <= '0;
    end else begin
      wr(WFB_ADDR_TRG_CFG, 16'h0400);
    end
    for (int k = 0; k < 60 && capture_active; k++) @(posedge clk_sys);
    #1 chk("capture_active", 32'h0, {31'h0, capture_active});
    rd(WFB_ADDR_TRG_STAT, {4'h1, 1'b0, 11'((n - 1) * 8)});
  endtask
  // Reads set 0 with the given burst code and neutral readout setting.
  task automatic burst(input logic [3:0] code, input logic nen);
    logic [7:0] m;
    int k;
    m = code == 0 ? 8'h3F : code == 1 ? 8'h03 : code == 2 ? 8'h0C : code == 3 ? 8'h30 : 8'h00;
    if (code == 0 || code == 4) m[6] = nen;
    if (m == 8'h00) m = 8'h20;
    wr(WFB_ADDR_BUF_CFG, {3'h0, nen, 8'h00, code});
    @(posedge clk_sys) rd_req <= 1'b1;
    rd_addr <= 11'h005;
    @(posedge clk_sys) rd_req <= 1'b0;
    #1;
    for (int c = 0; c < 8; c++) begin
      if (m[c]) begin
        k = 0;
        while (!rd_valid && k < 9) begin
          @(posedge clk_sys);
          #1 k++;
        end
        chk("rd_data", {seqs[0], 13'h0000, 3'(c)} ^ {32{inv}}, rd_data);
        chk("rd_last", {31'h0, (m >> (c + 1)) == 8'h00}, {31'h0, rd_last});
        @(posedge clk_sys);
        #1;
      end
    end
  endtask
  // Fills with cfg, forces a trigger after pre sets and checks stop, last page and trigger address.
  // A resampled fill leaves the last page at the 1 that the trigger captures left behind.
  task automatic fill(input logic [15:0] cfg, input int pre, input int post);
    wr(WFB_ADDR_BUF_CFG, 16'h0000);
    wr(WFB_ADDR_TRG_CFG, 16'h0000);
    n = 0;
    use_8k = cfg[9];
    inv = !cfg[5];
    wr(WFB_ADDR_BUF_CFG, cfg);
    wait_n(pre);
    wr(WFB_ADDR_TRG_CFG, 16'h0400);
    for (int k = 0; k < 12000 && capture_active; k++) @(posedge clk_sys);
    #1 chk("capture_active", 32'h0, {31'h0, capture_active});
    rd(WFB_ADDR_TRG_STAT, {cfg[5] ? 4'(n / 16 - 1) : 4'h1, 1'b0, 11'((n - 1 - post) * 8)});
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(WFB_ADDR_BUF_CFG, 16'h0000);
    rd(WFB_ADDR_TRG_CFG, 16'h0000);
    rd(WFB_ADDR_TRG_STAT, 16'h0000);
    wr(WFB_ADDR_BUF_CFG, 16'hFFEF);
    rd(WFB_ADDR_BUF_CFG, 16'h13EF);
    wr(WFB_ADDR_TRG_CFG, 16'hFBFF);
    rd(WFB_ADDR_TRG_CFG, 16'h03FF);
    for (int i = 0; i <= 10; i++) capture(i);
    for (int j = 0; j < 12; j++) burst(4'(codes[j / 2]), j[0]);
    fill(16'h0050, 2, 0);
    burst(4'hF, 1'b0);
    burst(4'h1, 1'b0);
    fill(16'h0270, 17, 0);
    fill(16'h00B0, 4, 128);
    conclude();
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    conclude();
  end
endmodule

bind wfb_capture_trigger wfb_trig_checker wfb_trig_checker_i (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rd_req(rd_req), .rd_valid(rd_valid), .rd_last(rd_last),
  .rd_busy(rd_busy), .capture_active(capture_active));
